// *** common/ldc_pkg.sv ***
`default_nettype none
package ldc_pkg;
  // ==========================================================
  // channels: index 0 is the low-current channel, 1..6 relays
  localparam int unsigned NCH        = 7;
  localparam int unsigned NRELAY     = 6;
  localparam int unsigned HOLD_CH_LO = 1;
  localparam int unsigned NHOLD      = 2;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned OVC_FILT_US = 4;
  localparam int unsigned OFF_FILT_US = 50;
  localparam int unsigned MASK_MIN_US = 300;
  localparam int unsigned HOLD_MIN_MS = 400;
  localparam int unsigned OVC_CYC     = OVC_FILT_US * CLK_MHZ;
  localparam int unsigned OFF_CYC     = OFF_FILT_US * CLK_MHZ;
  localparam int unsigned MASK_CYC    = MASK_MIN_US * CLK_MHZ;
  localparam int unsigned HOLD_CYC    = HOLD_MIN_MS * 1000 * CLK_MHZ;

  // ==========================================================
  // register map (byte addresses, low byte of haddr)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD  = 8'h04;
  localparam logic [7:0] OFF_DIAG = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;

  // control word fields
  localparam int unsigned CTRL_W          = 4;
  localparam int unsigned CTRL_GDIS_BIT   = 0;
  localparam int unsigned CTRL_OFFDIS_BIT = 1;
  localparam int unsigned CTRL_HOLD_LSB   = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
  localparam logic [NCH-1:0]    CMD_RST   = 7'h00;

  // status word fields
  localparam int unsigned STAT_OUT_LSB  = 0;
  localparam int unsigned STAT_OVC_LSB  = 7;
  localparam int unsigned STAT_HOLD_LSB = 14;
  localparam int unsigned STAT_W        = 16;

  // fault codes, two bits per channel
  localparam logic [1:0] FLT_OK  = 2'h3;
  localparam logic [1:0] FLT_OL  = 2'h1;
  localparam logic [1:0] FLT_SGB = 2'h2;
  localparam logic [1:0] FLT_SCG = 2'h0;
  localparam logic [2*NCH-1:0] DIAG_RST = 14'h3fff;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ==========================================================
  // comparator results from the analog drivers
  typedef struct packed {
    logic [NCH-1:0] ovc;
    logic [NCH-1:0] above_lvt;
    logic [NCH-1:0] above_hvt;
  } ldc_cmp_s;

  typedef enum logic {HS_IDLE, HS_HOLD} ldc_hold_e;
endpackage
`default_nettype wire

// *** logic/ldc_persist.sv ***
`default_nettype none
// ============================================================
// persistence filter: hit once level has stood COUNT cycles
module ldc_persist
  import ldc_pkg::*;
#(
  parameter int unsigned COUNT = OVC_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic level,
  output logic      hit
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] CMAX = CW'(COUNT);

  if (COUNT < 1) begin : g_bad_count
    $error("persistence count must be at least one");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // any drop of the level restarts the count
  assign cnt_nxt = !level ? '0 : ((cnt_r == CMAX) ? cnt_r : cnt_r + 1'b1);
  assign hit     = level && (cnt_r == CMAX);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_persist_restart: assert property (@(posedge core_clk) disable iff (!nrst)
    !level |=> cnt_r == '0) else $error("filter count not restarted");
endmodule
`default_nettype wire

// *** logic/ldc_lowside_ctrl.sv ***
// Added by the designer: the address map and the AHB-Lite register port.
`default_nettype none
module ldc_lowside_ctrl
  import ldc_pkg::*;
#(
  parameter int unsigned OVC_FILT_CYC  = OVC_CYC,
  parameter int unsigned OFF_FILT_CYC  = OFF_CYC,
  parameter int unsigned MASK_DLY_CYC  = MASK_CYC,
  parameter int unsigned HOLD_TIME_CYC = HOLD_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        chip_reset_n,
  input  wire logic        battery_low_level,
  input  wire ldc_cmp_s    cmp,
  output logic             low_current_output,
  output logic [NRELAY-1:0] relay_outputs
);
  localparam int unsigned MW = $clog2(MASK_DLY_CYC + 1);
  localparam int unsigned HW = $clog2(HOLD_TIME_CYC);
  localparam logic [MW-1:0] MASK_DONE = MW'(MASK_DLY_CYC);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_TIME_CYC - 1);

  if (MASK_DLY_CYC < 1 || HOLD_TIME_CYC < 2) begin : g_bad_time
    $error("mask and hold counts too small");
  end

  // ==========================================================
  // input synchronisers
  ldc_cmp_s cmp_m_r;
  ldc_cmp_s cmp_s_r;
  logic     crst_n_m_r;
  logic     crst_n_s_r;
  logic     batt_m_r;
  logic     batt_s_r;
  logic     crst_q_r;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmp_m_r    <= '0;
      cmp_s_r    <= '0;
      crst_n_m_r <= 1'b0;
      crst_n_s_r <= 1'b0;
      batt_m_r   <= 1'b0;
      batt_s_r   <= 1'b0;
      crst_q_r   <= 1'b1;
    end else begin
      cmp_m_r    <= cmp;
      cmp_s_r    <= cmp_m_r;
      crst_n_m_r <= chip_reset_n;
      crst_n_s_r <= crst_n_m_r;
      batt_m_r   <= battery_low_level;
      batt_s_r   <= batt_m_r;
      crst_q_r   <= !crst_n_s_r;
    end
  end

  wire crst      = !crst_n_s_r;
  wire crst_edge = crst && !crst_q_r;

  // ==========================================================
  // bus slave: zero wait states, read data in the data phase
  logic [CTRL_W-1:0] ctrl_r;
  logic [NCH-1:0]    cmd_r;
  logic [2*NCH-1:0]  diag_r;
  logic [NCH-1:0]    out_r;
  logic [NCH-1:0]    ovc_off_r;
  logic [NHOLD-1:0]  hold_ch_r;
  logic              wr_pend_r;
  logic [7:0]        wr_addr_r;
  logic [31:0]       hrdata_r;
  logic              hreadyout_r;

  wire       hi_zero = (haddr[31:8] == 24'h0);
  wire       acc     = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  wire       rd_acc  = acc && !hwrite;
  wire [7:0] a_lo    = hi_zero ? haddr[7:0] : 8'hff;
  wire       rd_clr  = rd_acc && (a_lo == OFF_DIAG);
  wire       wr_ctrl = wr_pend_r && (wr_addr_r == OFF_CTRL);
  wire       cmd_wr  = wr_pend_r && (wr_addr_r == OFF_CMD);

  wire [STAT_W-1:0] stat_word = {hold_ch_r, ovc_off_r, out_r};

  wire [31:0] rd_word =
    (a_lo == OFF_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl_r} :
    (a_lo == OFF_CMD)  ? {{(32-NCH){1'b0}}, cmd_r} :
    (a_lo == OFF_DIAG) ? {{(32-2*NCH){1'b0}}, diag_r} :
    (a_lo == OFF_STAT) ? {{(32-STAT_W){1'b0}}, stat_word} :
    32'h0;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'hff;
      hrdata_r    <= 32'h0;
      hreadyout_r <= 1'b1;
    end else begin
      wr_pend_r   <= acc && hwrite;
      wr_addr_r   <= a_lo;
      hrdata_r    <= rd_acc ? rd_word : 32'h0;
      hreadyout_r <= 1'b1;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  // error responses never occur, so the flop holds zero
  logic hresp_r;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end
  assign hresp = hresp_r;

  // ==========================================================
  // control and command words
  wire gdis   = ctrl_r[CTRL_GDIS_BIT];
  wire offdis = ctrl_r[CTRL_OFFDIS_BIT];
  wire [NHOLD-1:0] hold_en = ctrl_r[CTRL_HOLD_LSB +: NHOLD];

  // chip reset wipes the commands: the host has to write them again
  wire [NCH-1:0] cmd_nxt = crst   ? CMD_RST :
                           cmd_wr ? hwdata[NCH-1:0] : cmd_r;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
      cmd_r  <= CMD_RST;
    end else begin
      ctrl_r <= wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl_r;
      cmd_r  <= cmd_nxt;
    end
  end

  // ==========================================================
  // low-battery hold of the first two relays
  ldc_hold_e        hs_r;
  ldc_hold_e        hs_nxt;
  logic [HW-1:0]    tmr_r;
  logic [HW-1:0]    tmr_nxt;
  logic [NHOLD-1:0] hold_ch_nxt;

  wire [NHOLD-1:0] hold_start =
    hold_en & out_r[HOLD_CH_LO +: NHOLD] & {NHOLD{batt_s_r}};
  wire hold_expire = (hs_r == HS_HOLD) && (tmr_r == HOLD_LAST);

  always_comb begin
    hs_nxt      = hs_r;
    tmr_nxt     = tmr_r;
    hold_ch_nxt = hold_ch_r;
    unique case (hs_r)
      HS_IDLE: begin
        if (crst_edge && (|hold_start)) begin
          hs_nxt      = HS_HOLD;
          tmr_nxt     = '0;
          hold_ch_nxt = hold_start;
        end
      end
      HS_HOLD: begin
        tmr_nxt = tmr_r + 1'b1;
        if (cmd_wr || hold_expire) begin
          hs_nxt      = HS_IDLE;
          hold_ch_nxt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hs_r      <= HS_IDLE;
      tmr_r     <= '0;
      hold_ch_r <= '0;
    end else begin
      hs_r      <= hs_nxt;
      tmr_r     <= tmr_nxt;
      hold_ch_r <= hold_ch_nxt;
    end
  end

  // ==========================================================
  // channels
  logic [NCH-1:0] ovc_hit;
  logic [NCH-1:0] sg_hit;
  logic [NCH-1:0] ol_hit;
  logic [NCH-1:0] diag_en;
  logic [NCH-1:0] on_nxt;
  logic [MW-1:0]  mask_cnt_r [NCH];

  wire [NCH-1:0] hold_vec = {{(NCH-NHOLD-1){1'b0}}, hold_ch_nxt, 1'b0};

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // low-current channel alone can drop its off-state diagnosis
    wire dis_i = (i == 0) && offdis;
    wire done  = (mask_cnt_r[i] == MASK_DONE);

    assign diag_en[i] = !out_r[i] && done && !dis_i;

    ldc_persist #(.COUNT(OVC_FILT_CYC)) u_ovc (
      .core_clk (core_clk),
      .nrst     (nrst),
      .level    (cmp_s_r.ovc[i] && out_r[i]),
      .hit      (ovc_hit[i])
    );
    ldc_persist #(.COUNT(OFF_FILT_CYC)) u_sg (
      .core_clk (core_clk),
      .nrst     (nrst),
      .level    (diag_en[i] && !cmp_s_r.above_lvt[i]),
      .hit      (sg_hit[i])
    );
    ldc_persist #(.COUNT(OFF_FILT_CYC)) u_ol (
      .core_clk (core_clk),
      .nrst     (nrst),
      .level    (diag_en[i] && cmp_s_r.above_lvt[i] && !cmp_s_r.above_hvt[i]),
      .hit      (ol_hit[i])
    );

    // a hold overrides chip reset, never the output disable
    assign on_nxt[i] = !gdis && !ovc_hit[i] && !ovc_off_r[i]
                       && (cmd_nxt[i] || hold_vec[i]);

    wire [1:0] code   = diag_r[2*i +: 2];
    wire       free   = (code == FLT_OK) || rd_clr;
    // an off-state fault only gives way to an overcurrent one
    wire [1:0] code_n = ovc_hit[i]          ? FLT_SGB :
                        (free && sg_hit[i]) ? FLT_SCG :
                        (free && ol_hit[i]) ? FLT_OL :
                        rd_clr              ? FLT_OK : code;
    wire cmd_fall = cmd_r[i] && !cmd_nxt[i];
    wire ovc_n    = ovc_hit[i]
                    || (ovc_off_r[i] && !rd_clr && !cmd_fall);

    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        mask_cnt_r[i]   <= '0;
        diag_r[2*i +: 2] <= FLT_OK;
        ovc_off_r[i]    <= 1'b0;
        out_r[i]        <= 1'b0;
      end else begin
        mask_cnt_r[i]   <= out_r[i] ? '0 : (done ? MASK_DONE : mask_cnt_r[i] + 1'b1);
        diag_r[2*i +: 2] <= code_n;
        ovc_off_r[i]    <= ovc_n;
        out_r[i]        <= on_nxt[i];
      end
    end

    a_ovc_switch_off: assert property (@(posedge core_clk) disable iff (!nrst)
      ovc_hit[i] |=> !out_r[i] && ovc_off_r[i] && code == FLT_SGB)
      else $error("overcurrent did not switch off and record");

    a_scg_latched: assert property (@(posedge core_clk) disable iff (!nrst)
      sg_hit[i] && !ovc_hit[i] && free |=> code == FLT_SCG)
      else $error("short to ground not latched");
  end

  assign low_current_output = out_r[0];
  assign relay_outputs      = out_r[NCH-1:1];

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_gdis_forces_off: assert property (
    gdis |=> out_r == '0) else $error("output on under output disable");

  a_crst_forces_off: assert property (
    crst && hold_ch_nxt == '0 |=> out_r == '0)
    else $error("output on during chip reset without hold");

  a_lc_cmd_only: assert property (
    out_r[0] |-> $past(cmd_r[0]) || $past(cmd_wr))
    else $error("low-current output on without command");

  a_hold_taken_back: assert property (
    hs_r == HS_HOLD && cmd_wr |=> hs_r == HS_IDLE && hold_ch_r == '0)
    else $error("hold not ended by command write");

  a_ovc_needs_run: assert property (
    (ovc_hit & ~(out_r & cmp_s_r.ovc & $past(out_r) & $past(cmp_s_r.ovc))) == '0)
    else $error("overcurrent accepted without persistence");

  a_mask_before_diag: assert property (
    $fell(out_r[2]) |-> ##1 (!sg_hit[2] && !ol_hit[2]) [*8])
    else $error("off-state fault inside mask delay");

  a_offdis_quiet: assert property (
    offdis |-> !sg_hit[0] && !ol_hit[0])
    else $error("off-state fault while diagnosis disabled");

  a_read_clears: assert property (
    rd_clr && ovc_hit == '0 && sg_hit == '0 && ol_hit == '0 |=> diag_r == DIAG_RST)
    else $error("diagnosis read did not clear codes");

  a_read_retries: assert property (
    rd_clr && !ovc_hit[3] |=> !ovc_off_r[3])
    else $error("overcurrent latch not released by read");

  a_hold_expires: assert property (
    hold_expire |=> hold_ch_r == '0 && hs_r == HS_IDLE)
    else $error("hold not ended at expiry");

  a_hold_keeps_on: assert property (
    hs_r == HS_IDLE && crst_edge && hold_start[0] && !gdis |=> out_r[1] ##1 out_r[1])
    else $error("held relay dropped at reset");

  c_ovc_trip:    cover property ((ovc_hit != '0) ##[1:60] rd_clr);
  c_hold_expire: cover property (hold_expire);
  c_hold_taken:  cover property (hs_r == HS_HOLD && cmd_wr);
  c_open_load:   cover property (ol_hit[1]);
endmodule
`default_nettype wire

// *** testbench/ldc_load_model.sv ***
`default_nettype none
// ==========================================================
// load side: turns fault codes per channel into comparator levels
module ldc_load_model
  import ldc_pkg::*;
(
  input  wire logic [NCH-1:0]   drv_on,
  input  wire logic [2*NCH-1:0] flt,
  output var  ldc_cmp_s         cmp
);
  logic [1:0] f;
  // a conducting switch pulls its pin low, so the voltage comparators read 0 while on
  always_comb begin
    f = 2'h3;
    for (int i = 0; i < NCH; i++) begin
      f = flt[2*i +: 2];
      cmp.ovc[i]       = drv_on[i] && (f == FLT_SGB);
      cmp.above_lvt[i] = !drv_on[i] && (f != FLT_SCG);
      cmp.above_hvt[i] = !drv_on[i] && (f != FLT_SCG) && (f != FLT_OL);
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_lowside_driver_ctrl_diag.sv ***
`default_nettype none
module tb_lowside_driver_ctrl_diag
  import ldc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OVC_P = 4, OFF_P = 8, MASK_P = 16, HOLD_P = 64;
  logic              core_clk = 1'b0;
  logic              nrst, hsel, hwrite, chip_reset_n, battery_low_level;
  logic              dp_rd = 1'b0;
  logic              dp_stat = 1'b0;
  logic [31:0]       haddr, hwdata, hrdata, v, e;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              hreadyout, hresp, low_current_output;
  logic [NRELAY-1:0] relay_outputs;
  logic [2*NCH-1:0]  load_flt;
  ldc_cmp_s          cmp;
  logic [31:0]       expq[$];
  int                err_count, checks_done, k;

  ldc_lowside_ctrl #(.OVC_FILT_CYC(OVC_P), .OFF_FILT_CYC(OFF_P), .MASK_DLY_CYC(MASK_P),
    .HOLD_TIME_CYC(HOLD_P)) u_ldc_lowside_ctrl (.core_clk(core_clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .chip_reset_n(chip_reset_n), .battery_low_level(battery_low_level),
    .cmp(cmp), .low_current_output(low_current_output), .relay_outputs(relay_outputs));
  ldc_load_model u_ldc_load_model (.drv_on({relay_outputs, low_current_output}),
    .flt(load_flt), .cmp(cmp));

  always #2.5 core_clk = ~core_clk;

  // ==========================================================
  // monitor: each read data phase is matched against the oldest note
  always @(posedge core_clk) begin
    if (dp_rd === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 32'hdead_beef;
      checks_done++;
      if (hrdata !== e || hresp !== 1'b0) begin
        err_count++;
        $display("BAD %0t read %h expected %h", $time, hrdata, e);
      end
      if (dp_stat === 1'b1 && {relay_outputs, low_current_output} !== e[6:0]) begin
        err_count++;
        $display("BAD %0t pins %h", $time, {relay_outputs, low_current_output});
      end
    end
    dp_rd <= hsel & htrans[1] & ~hwrite & hreadyout;
    dp_stat <= (haddr[7:0] == OFF_STAT);
  end

  // ==========================================================
  // bus master
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  function automatic logic [31:0] st(input logic [1:0] h, input logic [6:0] o,
                                     input logic [6:0] c);
    return {16'h0, h, c, o};
  endfunction
  function automatic logic [31:0] dg(input int ch, input logic [1:0] c);
    return ({18'h0, DIAG_RST} & ~(32'h3 << (2*ch))) | ({30'h0, c} << (2*ch));
  endfunction

  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #50us;
    err_count++;
    give_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    {nrst, hsel, hwrite, chip_reset_n, battery_low_level} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = HSIZE_WORD;
    load_flt = DIAG_RST;
    err_count = 0;
    checks_done = 0;
    v = $urandom(32'h73a1);
    idle(6);
    nrst <= 1'b1;
    chip_reset_n <= 1'b1;
    idle(4);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_CMD, 32'h0);
    rd(OFF_DIAG, {18'h0, DIAG_RST});
    rd(OFF_STAT, 32'h0);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 32'h7f;
      wr(OFF_CMD, v);
      rd(OFF_STAT, st(2'h0, v[6:0], 7'h0));
    end
    hsize <= 3'h0;
    wr(OFF_CMD, 32'h7f);
    hsize <= HSIZE_WORD;
    rd(OFF_CMD, v);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STAT, 32'h0);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STAT, st(2'h0, v[6:0], 7'h0));
    chip_reset_n <= 1'b0;
    idle(4);
    rd(OFF_STAT, 32'h0);
    chip_reset_n <= 1'b1;
    idle(4);
    // short glitch must not trip; a lasting one must
    wr(OFF_CMD, 32'h7f);
    k = $urandom_range(6, 0);
    load_flt <= dg(k, FLT_SGB);
    idle(2);
    load_flt <= DIAG_RST;
    idle(6);
    rd(OFF_DIAG, {18'h0, DIAG_RST});
    load_flt <= dg(k, FLT_SGB);
    idle(OVC_P + 8);
    rd(OFF_STAT, st(2'h0, 7'h7f & ~(7'h1 << k), 7'h1 << k));
    load_flt <= DIAG_RST;
    rd(OFF_DIAG, dg(k, FLT_SGB));
    idle(3);
    rd(OFF_STAT, st(2'h0, 7'h7f, 7'h0));
    rd(OFF_DIAG, {18'h0, DIAG_RST});
    load_flt <= dg(k, FLT_SGB);
    idle(OVC_P + 8);
    load_flt <= DIAG_RST;
    wr(OFF_CMD, 32'h7f & ~(32'h1 << k));
    wr(OFF_CMD, 32'h7f);
    rd(OFF_STAT, st(2'h0, 7'h7f, 7'h0));
    rd(OFF_DIAG, dg(k, FLT_SGB));
    // off-state faults on relays 1 and 2
    load_flt <= dg(1, FLT_OL) & dg(2, FLT_SCG);
    wr(OFF_CMD, 32'h79);
    idle(4);
    rd(OFF_DIAG, {18'h0, DIAG_RST});
    idle(MASK_P + OFF_P + 8);
    load_flt <= DIAG_RST;
    idle(4);
    rd(OFF_DIAG, dg(1, FLT_OL) & dg(2, FLT_SCG));
    rd(OFF_DIAG, {18'h0, DIAG_RST});
    wr(OFF_CTRL, 32'h2);
    wr(OFF_CMD, 32'h7e);
    load_flt <= dg(0, FLT_SCG);
    idle(MASK_P + OFF_P + 8);
    rd(OFF_DIAG, {18'h0, DIAG_RST});
    wr(OFF_CTRL, 32'h0);
    idle(OFF_P + 8);
    rd(OFF_DIAG, dg(0, FLT_SCG));
    load_flt <= DIAG_RST;
    // low-battery hold, host takes over in time
    wr(OFF_CTRL, 32'hc);
    wr(OFF_CMD, 32'h0e);
    battery_low_level <= 1'b1;
    chip_reset_n <= 1'b0;
    idle(10);
    rd(OFF_STAT, st(2'h3, 7'h06, 7'h0));
    chip_reset_n <= 1'b1;
    battery_low_level <= 1'b0;
    idle(4);
    wr(OFF_CMD, 32'h04);
    rd(OFF_STAT, st(2'h0, 7'h04, 7'h0));
    // hold on the first relay only, left to expire
    wr(OFF_CTRL, 32'h4);
    wr(OFF_CMD, 32'h06);
    battery_low_level <= 1'b1;
    chip_reset_n <= 1'b0;
    idle(10);
    rd(OFF_STAT, st(2'h1, 7'h02, 7'h0));
    idle(30);
    rd(OFF_STAT, st(2'h1, 7'h02, 7'h0));
    idle(30);
    rd(OFF_STAT, 32'h0);
    chip_reset_n <= 1'b1;
    battery_low_level <= 1'b0;
    idle(4);
    give_verdict();
  end
endmodule
`default_nettype wire
